// ### logic/sir_defs.svh
// constants of the switch ingress register block
`ifndef SIR_DEFS_SVH
`define SIR_DEFS_SVH

// bus widths
`define SIR_AW 16
`define SIR_IW 14

// register indices, byte address is four times the index
`define SIR_IDX_CMD_STATE 14'h184C
`define SIR_IDX_WR_STAGE 14'h184D
`define SIR_IDX_RD_STAGE 14'h184E
`define SIR_IDX_DROP0 14'h1850
`define SIR_IDX_DROP1 14'h1851
`define SIR_IDX_DROP2 14'h1852
`define SIR_IDX_MAP0 14'h1855
`define SIR_IDX_MAP1 14'h1856

// field layouts
`define SIR_STAGE_W 16
`define SIR_MAP_W 24
`define SIR_PRIO_W 3
`define SIR_PORTS 3

// reset values
`define SIR_STAGE_RESET 16'h0000
`define SIR_CNT_RESET 32'h00000000
`define SIR_MAP_RESET 24'hFAC688

// counter ceiling
`define SIR_CNT_MAX 32'hFFFFFFFF
`define SIR_CNT_ONE 32'h00000001

// axi responses
`define SIR_RESP_OKAY 2'h0
`define SIR_RESP_SLVERR 2'h2

`endif

// ### logic/sir_pkg.sv
// types of the switch ingress register block
`include "sir_defs.svh"

package sir_pkg;

   // full state of the register block
   typedef struct packed {
      logic aw_have;                         // write address held
      logic [`SIR_IW-1:0] aw_idx;            // held write index
      logic w_have;                          // write data held
      logic [31:0] w_data;                   // held write data
      logic [3:0] w_strb;                    // held byte enables
      logic bvalid;                          // write answer pending
      logic [1:0] bresp;                     // write answer code
      logic rvalid;                          // read answer pending
      logic [31:0] rdata;                    // read answer data
      logic [1:0] rresp;                     // read answer code
      logic [`SIR_IW-1:0] rd_idx;            // index of last read
      logic [`SIR_STAGE_W-1:0] wstage;       // rate write staging
      logic [`SIR_STAGE_W-1:0] rstage;       // rate read staging
      logic pending;                         // rate command busy
      logic [`SIR_MAP_W-1:0] map0;           // port 0 remap
      logic [`SIR_MAP_W-1:0] map1;           // port 1 remap
      logic q0_valid;                        // port 0 result valid
      logic [`SIR_PRIO_W-1:0] q0_prio;       // port 0 result prio
      logic q1_valid;                        // port 1 result valid
      logic [`SIR_PRIO_W-1:0] q1_prio;       // port 1 result prio
   } sir_regs_t;

   // state of one drop counter
   typedef struct packed {
      logic [31:0] count;                    // saturating tally
   } sir_cnt_t;

endpackage

// ### logic/sir_drop_counter.sv
// saturating clear-on-read drop counter of one port
`timescale 1ns/1ps
`include "sir_defs.svh"

module sir_drop_counter (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic aclk_en,
   input wire logic inc,
   input wire logic clr,
   output logic [31:0] count
);

   sir_pkg::sir_cnt_t c_q;                   // registered state
   sir_pkg::sir_cnt_t c_d;                   // next state

   // next count: clear by read, then count, stop at the top
   always_comb begin
      c_d = c_q;
      if (clr) begin
         // a packet in the read cycle is kept as the new first count
         c_d.count = inc ? `SIR_CNT_ONE : `SIR_CNT_RESET;
      end else if (inc && c_q.count != `SIR_CNT_MAX) begin
         c_d.count = c_q.count + `SIR_CNT_ONE;
      end
   end

   // register, frozen while the enable is low
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         c_q <= '0;
      end else if (aclk_en) begin
         c_q <= c_d;
      end
   end

   assign count = c_q.count;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   cnt_step_a: assert property (aclk_en && inc && !clr &&
      count != `SIR_CNT_MAX |=> count == $past(count) + `SIR_CNT_ONE)
      else $error("drop counter did not step");
   cnt_sat_a: assert property (aclk_en && !clr &&
      count == `SIR_CNT_MAX |=> count == `SIR_CNT_MAX)
      else $error("drop counter left its ceiling");
   cnt_clear_a: assert property (aclk_en && clr && !inc
      |=> count == `SIR_CNT_RESET)
      else $error("drop counter not cleared by read");
   cnt_hold_a: assert property (!aclk_en |=> $stable(count))
      else $error("drop counter moved while frozen");

endmodule

// ### logic/sir_ingress_regs.sv
// switch ingress register block: rate staging, drop counts, remaps
// Operation
// - write staging holds 16 bits, resets zero
// - read staging shows last fetched table value
// - pending set during command, self-clears after
// - one 32-bit drop counter per port
// - counter counts every ingress-filtered packet
// - rate-limit drops are not counted here
// - reading returns count and clears it
// - counters stop at all ones
// - ports 0 and 1 each have a map regenerating received tagged priority
// - regenerated priority feeds queue selection
// - eight 3-bit fields, top byte reserved
// - maps reset to identity
// - staging upper half reads zero, ignores writes
`timescale 1ns/1ps
`include "sir_defs.svh"

module sir_ingress_regs (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic aclk_en,
   // axi4-lite write address
   input wire logic [`SIR_AW-1:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic awvalid,
   output logic awready,
   // axi4-lite write data
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // axi4-lite write answer
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // axi4-lite read address
   input wire logic [`SIR_AW-1:0] araddr,
   input wire logic [2:0] arprot,
   input wire logic arvalid,
   output logic arready,
   // axi4-lite read answer
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // rate table engine side
   input wire logic rate_cmd_start,
   input wire logic rate_cmd_done,
   input wire logic rate_rd_valid,
   input wire logic [`SIR_STAGE_W-1:0] rate_rd_data,
   output logic [`SIR_STAGE_W-1:0] rate_wr_data,
   output logic rate_cmd_pending,
   // ingress discard events per port
   input wire logic [`SIR_PORTS-1:0] drop_valid,
   input wire logic [`SIR_PORTS-1:0] drop_by_rate,
   // tagged received priority per port
   input wire logic rx0_valid,
   input wire logic [`SIR_PRIO_W-1:0] rx0_prio,
   input wire logic rx1_valid,
   input wire logic [`SIR_PRIO_W-1:0] rx1_prio,
   // regenerated priority toward queue selection
   output logic q0_valid,
   output logic [`SIR_PRIO_W-1:0] q0_prio,
   output logic q1_valid,
   output logic [`SIR_PRIO_W-1:0] q1_prio
);

   // reset image of the whole state
   localparam sir_pkg::sir_regs_t SIR_RESET_STATE = '{
      wstage: `SIR_STAGE_RESET,
      rstage: `SIR_STAGE_RESET,
      map0: `SIR_MAP_RESET,
      map1: `SIR_MAP_RESET,
      bresp: `SIR_RESP_OKAY,
      rresp: `SIR_RESP_OKAY,
      default: '0
   };

   sir_pkg::sir_regs_t s_q;                  // registered state
   sir_pkg::sir_regs_t s_d;                  // next state
   logic [`SIR_PORTS-1:0] cnt_inc;           // counted discards
   logic [`SIR_PORTS-1:0] cnt_clr;           // clear-by-read pulses
   logic [`SIR_PORTS-1:0][31:0] cnt_val;     // counter values

   // merge written bytes into an old word under the byte enables
   function automatic logic [31:0] sir_merge(
      input logic [31:0] old_w,
      input logic [31:0] new_w,
      input logic [3:0] strb
   );
      logic [31:0] res;
      res = old_w;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = new_w[b*8 +: 8];
         end
      end
      return res;
   endfunction

   // look up the regenerated priority of one received priority
   function automatic logic [`SIR_PRIO_W-1:0] sir_remap(
      input logic [`SIR_MAP_W-1:0] map,
      input logic [`SIR_PRIO_W-1:0] prio
   );
      return map[prio*`SIR_PRIO_W +: `SIR_PRIO_W];
   endfunction

   // handshakes refuse while frozen or while a slot is full
   assign awready = aclk_en && !s_q.aw_have;
   assign wready = aclk_en && !s_q.w_have;
   assign arready = aclk_en && !s_q.rvalid;

   // rate-limit discards are left to their own tally
   assign cnt_inc = drop_valid & ~drop_by_rate;

   // one saturating counter per port, consecutive indices
   for (genvar g = 0; g < `SIR_PORTS; g++) begin : g_cnt
      sir_drop_counter u_cnt (
         .aclk(aclk),
         .aresetn(aresetn),
         .aclk_en(aclk_en),
         .inc(cnt_inc[g]),
         .clr(cnt_clr[g]),
         .count(cnt_val[g])
      );
   end

   // next-state logic of bus slave, staging, flag and remap
   always_comb begin
      logic [31:0] merged;
      merged = '0;
      s_d = s_q;
      cnt_clr = '0;
      // answers leave once taken
      if (s_q.bvalid && bready) begin
         s_d.bvalid = 1'b0;
      end
      if (s_q.rvalid && rready) begin
         s_d.rvalid = 1'b0;
      end
      // address and data are caught in either order
      if (awvalid && awready) begin
         s_d.aw_have = 1'b1;
         s_d.aw_idx = awaddr[`SIR_AW-1:2];
      end
      if (wvalid && wready) begin
         s_d.w_have = 1'b1;
         s_d.w_data = wdata;
         s_d.w_strb = wstrb;
      end
      // perform the write once both halves are held
      if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
         s_d.aw_have = 1'b0;
         s_d.w_have = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = `SIR_RESP_OKAY;
         case (s_q.aw_idx)
            `SIR_IDX_WR_STAGE: begin
               // upper half dropped on the floor
               merged = sir_merge({16'h0000, s_q.wstage}, s_q.w_data,
                  s_q.w_strb);
               s_d.wstage = merged[`SIR_STAGE_W-1:0];
            end
            `SIR_IDX_MAP0: begin
               merged = sir_merge({8'h00, s_q.map0}, s_q.w_data,
                  s_q.w_strb);
               s_d.map0 = merged[`SIR_MAP_W-1:0];
            end
            `SIR_IDX_MAP1: begin
               merged = sir_merge({8'h00, s_q.map1}, s_q.w_data,
                  s_q.w_strb);
               s_d.map1 = merged[`SIR_MAP_W-1:0];
            end
            // read-only words accept and ignore writes
            `SIR_IDX_CMD_STATE, `SIR_IDX_RD_STAGE, `SIR_IDX_DROP0,
            `SIR_IDX_DROP1, `SIR_IDX_DROP2: begin
               s_d.bresp = `SIR_RESP_OKAY;
            end
            // nothing lives here
            default: begin
               s_d.bresp = `SIR_RESP_SLVERR;
            end
         endcase
      end
      // read: data registered at the accepting edge
      if (arvalid && arready) begin
         s_d.rvalid = 1'b1;
         s_d.rd_idx = araddr[`SIR_AW-1:2];
         s_d.rresp = `SIR_RESP_OKAY;
         case (araddr[`SIR_AW-1:2])
            `SIR_IDX_CMD_STATE: begin
               s_d.rdata = {31'h00000000, s_q.pending};
            end
            `SIR_IDX_WR_STAGE: begin
               s_d.rdata = {16'h0000, s_q.wstage};
            end
            `SIR_IDX_RD_STAGE: begin
               s_d.rdata = {16'h0000, s_q.rstage};
            end
            `SIR_IDX_DROP0: begin
               s_d.rdata = cnt_val[0];
               cnt_clr[0] = 1'b1;
            end
            `SIR_IDX_DROP1: begin
               s_d.rdata = cnt_val[1];
               cnt_clr[1] = 1'b1;
            end
            `SIR_IDX_DROP2: begin
               s_d.rdata = cnt_val[2];
               cnt_clr[2] = 1'b1;
            end
            `SIR_IDX_MAP0: begin
               s_d.rdata = {8'h00, s_q.map0};
            end
            `SIR_IDX_MAP1: begin
               s_d.rdata = {8'h00, s_q.map1};
            end
            default: begin
               s_d.rdata = 32'h00000000;
               s_d.rresp = `SIR_RESP_SLVERR;
            end
         endcase
      end
      // pending flag: a new start beats a finishing command
      if (rate_cmd_done) begin
         s_d.pending = 1'b0;
      end
      if (rate_cmd_start) begin
         s_d.pending = 1'b1;
      end
      // value fetched by the latest table read
      if (rate_rd_valid) begin
         s_d.rstage = rate_rd_data;
      end
      // regenerated priority handed to queue selection
      s_d.q0_valid = rx0_valid;
      s_d.q0_prio = sir_remap(s_q.map0, rx0_prio);
      s_d.q1_valid = rx1_valid;
      s_d.q1_prio = sir_remap(s_q.map1, rx1_prio);
   end

   // state register, frozen while the enable is low
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= SIR_RESET_STATE;
      end else if (aclk_en) begin
         s_q <= s_d;
      end
   end

   // outputs straight from the state
   assign bvalid = s_q.bvalid;
   assign bresp = s_q.bresp;
   assign rvalid = s_q.rvalid;
   assign rdata = s_q.rdata;
   assign rresp = s_q.rresp;
   assign rate_wr_data = s_q.wstage;
   assign rate_cmd_pending = s_q.pending;
   assign q0_valid = s_q.q0_valid;
   assign q0_prio = s_q.q0_prio;
   assign q1_valid = s_q.q1_valid;
   assign q1_prio = s_q.q1_prio;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   pend_set_a: assert property (aclk_en && rate_cmd_start
      |=> rate_cmd_pending)
      else $error("pending flag not set by command start");
   pend_clear_a: assert property (aclk_en && rate_cmd_done &&
      !rate_cmd_start |=> !rate_cmd_pending)
      else $error("pending flag did not self-clear");
   rstage_load_a: assert property (aclk_en && rate_rd_valid
      |=> s_q.rstage == $past(rate_rd_data))
      else $error("read staging missed fetched value");
   rate_skip_a: assert property (drop_by_rate != '0
      |-> (cnt_inc & drop_by_rate) == '0)
      else $error("rate-limit discard was counted");
   remap_out_a: assert property (aclk_en && rx0_valid
      |=> q0_valid && q0_prio == sir_remap($past(s_q.map0),
      $past(rx0_prio)))
      else $error("port 0 regenerated priority wrong");
   remap_init_a: assert property ($rose(aresetn)
      |-> s_q.map0 == `SIR_MAP_RESET && s_q.map1 == `SIR_MAP_RESET)
      else $error("remap not identity after reset");
   map_rsvd_a: assert property (rvalid && (s_q.rd_idx ==
      `SIR_IDX_MAP0 || s_q.rd_idx == `SIR_IDX_MAP1)
      |-> rdata[31:24] == 8'h00)
      else $error("remap reserved byte not zero");
   stage_rsvd_a: assert property (rvalid && (s_q.rd_idx ==
      `SIR_IDX_WR_STAGE || s_q.rd_idx == `SIR_IDX_RD_STAGE)
      |-> rdata[31:16] == 16'h0000)
      else $error("staging upper half not zero");
   read_clear_a: assert property (aclk_en && arvalid && arready &&
      araddr[`SIR_AW-1:2] == `SIR_IDX_DROP1 && !cnt_inc[1]
      |=> rdata == $past(cnt_val[1]) && cnt_val[1] == `SIR_CNT_RESET)
      else $error("port 1 count not returned and cleared");
   b_hold_a: assert property (bvalid && !bready |=> bvalid)
      else $error("write answer dropped before taken");

   wstage_write_c: cover property (bvalid && s_q.bresp ==
      `SIR_RESP_OKAY ##0 s_q.wstage != `SIR_STAGE_RESET);
   count_read_c: cover property (rvalid && s_q.rd_idx ==
      `SIR_IDX_DROP0 && rdata != `SIR_CNT_RESET);
   remap_used_c: cover property (q1_valid && q1_prio != 3'h0 &&
      s_q.map1 != `SIR_MAP_RESET);
   pend_cycle_c: cover property (rate_cmd_pending ##[1:20]
      !rate_cmd_pending);

endmodule

// ### sim/tb_top.sv
// self-checking bench of the switch ingress register block
`timescale 1ns/1ps
`include "sir_defs.svh"

module tb_top;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic aclk_en = 1'b1;
   logic [15:0] awaddr = 16'h0000;
   logic awvalid = 1'b0;
   logic [31:0] wdata = 32'h00000000;
   logic [3:0] wstrb = 4'hF;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic [15:0] araddr = 16'h0000;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic start = 1'b0;
   logic done = 1'b0;
   logic rd_valid = 1'b0;
   logic [15:0] rd_data = 16'h0000;
   logic [2:0] drop_valid = 3'h0;
   logic [2:0] drop_by_rate = 3'h0;
   logic rx0_valid = 1'b0;
   logic [2:0] rx0_prio = 3'h0;
   logic rx1_valid = 1'b0;
   logic [2:0] rx1_prio = 3'h0;
   logic awready, wready, bvalid, arready, rvalid, pending;
   logic q0_valid, q1_valid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [15:0] wr_stage;
   logic [2:0] q0_prio, q1_prio;
   int n_fail = 0;
   int checked = 0;
   int cyc = 0;
   // byte addresses, four times the register index
   localparam logic [15:0] A_CMD = {`SIR_IDX_CMD_STATE, 2'b00};
   localparam logic [15:0] A_WR = {`SIR_IDX_WR_STAGE, 2'b00};
   localparam logic [15:0] A_RD = {`SIR_IDX_RD_STAGE, 2'b00};
   localparam logic [15:0] A_DROP0 = {`SIR_IDX_DROP0, 2'b00};
   localparam logic [15:0] A_MAP0 = {`SIR_IDX_MAP0, 2'b00};
   localparam logic [15:0] A_MAP1 = {`SIR_IDX_MAP1, 2'b00};
   localparam logic [15:0] A_HOLE = 16'h613C;

   sir_ingress_regs i_dut (
      .aclk(aclk), .aresetn(aresetn), .aclk_en(aclk_en),
      .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arprot(3'h0), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .rate_cmd_start(start), .rate_cmd_done(done),
      .rate_rd_valid(rd_valid), .rate_rd_data(rd_data),
      .rate_wr_data(wr_stage), .rate_cmd_pending(pending),
      .drop_valid(drop_valid), .drop_by_rate(drop_by_rate),
      .rx0_valid(rx0_valid), .rx0_prio(rx0_prio),
      .rx1_valid(rx1_valid), .rx1_prio(rx1_prio),
      .q0_valid(q0_valid), .q0_prio(q0_prio),
      .q1_valid(q1_valid), .q1_prio(q1_prio)
   );

   // 100 MHz clock
   always #5 aclk = ~aclk;

   // hang guard, counted as a mismatch
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail = n_fail + 1;
         end_sim();
      end
   end

   // counts, verdict and end of run
   task automatic end_sim();
      $display("checked %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // compare one value, four-state exact
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string what);
      checked = checked + 1;
      if (got !== exp) begin
         n_fail = n_fail + 1;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // one bus write, address and data offered together
   task automatic axi_wr(input logic [15:0] a, input logic [31:0] d,
                         output logic [1:0] r);
      bit aw_hit, w_hit, aw_done, w_done, b_hit;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      aw_done = 0;
      w_done = 0;
      while (!(aw_done && w_done)) begin
         @(negedge aclk);
         aw_hit = awvalid && awready;
         w_hit = wvalid && wready;
         @(posedge aclk);
         if (aw_hit) begin
            awvalid <= 1'b0;
            aw_done = 1;
         end
         if (w_hit) begin
            wvalid <= 1'b0;
            w_done = 1;
         end
      end
      do begin
         @(negedge aclk);
         b_hit = (bvalid === 1'b1);
         r = bresp;
         @(posedge aclk);
      end while (!b_hit);
      bready <= 1'b0;
   endtask

   // one bus read
   task automatic axi_rd(input logic [15:0] a, output logic [31:0] d,
                         output logic [1:0] r);
      bit hit;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(negedge aclk);
         hit = arvalid && arready;
         @(posedge aclk);
      end while (!hit);
      arvalid <= 1'b0;
      do begin
         @(negedge aclk);
         hit = (rvalid === 1'b1);
         d = rdata;
         r = rresp;
         @(posedge aclk);
      end while (!hit);
      rready <= 1'b0;
   endtask

   // read a word and compare data and answer code
   task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp,
                         input logic [1:0] er);
      logic [31:0] d;
      logic [1:0] r;
      axi_rd(a, d, r);
      chk(d, exp, "read data");
      chk({30'h0, r}, {30'h0, er}, "read resp");
   endtask

   // reset values of every mapped word
   task automatic t_reset();
      rd_chk(A_CMD, 32'h00000000, `SIR_RESP_OKAY);
      rd_chk(A_WR, 32'h00000000, `SIR_RESP_OKAY);
      rd_chk(A_RD, 32'h00000000, `SIR_RESP_OKAY);
      for (int p = 0; p < 3; p++) begin
         rd_chk(A_DROP0 + 16'(4 * p), 32'h00000000, `SIR_RESP_OKAY);
      end
      rd_chk(A_MAP0, 32'h00FAC688, `SIR_RESP_OKAY);
      rd_chk(A_MAP1, 32'h00FAC688, `SIR_RESP_OKAY);
   endtask

   // staging words: low half kept, upper half and read stage fixed
   task automatic t_stage();
      logic [1:0] r;
      axi_wr(A_WR, 32'hFFFF_A5C3, r);
      chk({30'h0, r}, {30'h0, `SIR_RESP_OKAY}, "write resp");
      rd_chk(A_WR, 32'h0000A5C3, `SIR_RESP_OKAY);
      chk({16'h0, wr_stage}, 32'h0000A5C3, "wr stage port");
      axi_wr(A_RD, 32'h1234_5678, r);
      rd_chk(A_RD, 32'h00000000, `SIR_RESP_OKAY);
      axi_wr(A_HOLE, 32'h0000_0001, r);
      chk({30'h0, r}, {30'h0, `SIR_RESP_SLVERR}, "hole write");
      rd_chk(A_HOLE, 32'h00000000, `SIR_RESP_SLVERR);
   endtask

   // table command: pending during command, fetched value shown
   task automatic t_cmd();
      @(posedge aclk);
      start <= 1'b1;
      @(posedge aclk);
      start <= 1'b0;
      @(negedge aclk);
      chk({31'h0, pending}, 32'h1, "pending set");
      rd_chk(A_CMD, 32'h00000001, `SIR_RESP_OKAY);
      @(posedge aclk);
      rd_valid <= 1'b1;
      rd_data <= 16'hBEEF;
      done <= 1'b1;
      @(posedge aclk);
      rd_valid <= 1'b0;
      rd_data <= 16'h4110;
      done <= 1'b0;
      @(negedge aclk);
      chk({31'h0, pending}, 32'h0, "pending clear");
      rd_chk(A_RD, 32'h0000BEEF, `SIR_RESP_OKAY);
   endtask

   // discards per port; rate-limit discards left out; clear on read
   task automatic t_drop();
      for (int i = 0; i < 5; i++) begin
         @(posedge aclk);
         drop_valid <= 3'h7;
         drop_by_rate <= (i < 3) ? 3'h0 : 3'h6;
      end
      @(posedge aclk);
      drop_valid <= 3'h0;
      drop_by_rate <= 3'h0;
      rd_chk(A_DROP0, 32'h00000005, `SIR_RESP_OKAY);
      rd_chk(A_DROP0 + 16'h4, 32'h00000003, `SIR_RESP_OKAY);
      rd_chk(A_DROP0 + 16'h8, 32'h00000003, `SIR_RESP_OKAY);
      for (int p = 0; p < 3; p++) begin
         rd_chk(A_DROP0 + 16'(4 * p), 32'h00000000, `SIR_RESP_OKAY);
      end
   endtask

   // reversed map on port 0, identity kept on port 1
   task automatic t_remap();
      logic [1:0] r;
      logic [31:0] m;
      m = 32'h0;
      for (int n = 0; n < 8; n++) begin
         m[3*n +: 3] = 3'(7 - n);
      end
      axi_wr(A_MAP0, {8'hFF, m[23:0]}, r);
      rd_chk(A_MAP0, m, `SIR_RESP_OKAY);
      for (int n = 0; n < 8; n++) begin
         @(posedge aclk);
         rx0_valid <= 1'b1;
         rx0_prio <= 3'(n);
         rx1_valid <= 1'b1;
         rx1_prio <= 3'(n);
         @(posedge aclk);
         rx0_valid <= 1'b0;
         rx1_valid <= 1'b0;
         @(negedge aclk);
         chk({31'h0, q0_valid}, 32'h1, "q0 valid");
         chk({29'h0, q0_prio}, 32'(7 - n), "q0 prio");
         chk({29'h0, q1_prio}, 32'(n), "q1 prio");
         chk({31'h0, q1_valid}, 32'h1, "q1 valid");
      end
   endtask

   // enable low: discards while frozen leave the tally alone
   task automatic t_freeze();
      @(posedge aclk);
      aclk_en <= 1'b0;
      drop_valid <= 3'h1;
      repeat (3) @(posedge aclk);
      aclk_en <= 1'b1;
      drop_valid <= 3'h0;
      rd_chk(A_DROP0, 32'h00000000, `SIR_RESP_OKAY);
   endtask

   // main sequence
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_stage();
      t_cmd();
      t_drop();
      t_remap();
      t_freeze();
      end_sim();
   end
endmodule
